//--- hw/pordm_top.sv
// por-disable key register and port 0 function/input-type register behind a wishbone slave
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`include "pordm_regs.svh"
module pordm_top #(
    parameter int PINS = 8 // port 0 width
) (
    input  wire logic                    ref_clk,              // 250 MHz system clock
    input  wire logic                    rst_n,                // synchronous reset, active low
    input  wire pordm_pkg::pordm_wb_req_t wb_req,              // wishbone classic request
    output pordm_pkg::pordm_wb_rsp_t     wb_rsp,               // wishbone classic answer
    input  wire logic                    write_unlocked,       // protection scheme is unlocked
    input  wire pordm_pkg::pordm_rst_src_t other_reset,        // other reset sources, asynchronous
    input  wire logic                    por_detect_raw,       // analog power-on detector, asynchronous
    output logic                         por_chip_reset,       // power-on reset request to the chip
    output logic                         por_disabled,         // power-on reset held off by key
    output logic [PINS-1:0]              port0_schmitt_enable, // schmitt input enable per pin
    input  wire logic [PINS-1:0]         p0_pin_in,            // pad input levels, asynchronous
    output logic [PINS-1:0]              p0_pin_out,           // pad output levels
    output logic [PINS-1:0]              p0_pin_oe,            // pad output enables, high drives
    input  wire logic [PINS-1:0]         gpio_out,             // gpio block output data
    input  wire logic [PINS-1:0]         gpio_oe,              // gpio block output enables
    output logic [PINS-1:0]              gpio_in,              // synchronised pad levels to gpio
    input  wire logic [5:0]              pwm_unit0_channel,    // pwm unit 0 channel outputs 0..5
    output logic                         pwm_unit0_brake_input1, // brake input 1 of pwm unit 0
    output logic                         adc_start_trigger_input, // adc external start trigger
    output logic [2:0]                   capture_unit1_input,  // capture unit 1 inputs 0..2
    output logic [PINS-1:0]              pin_is_gpio           // pin currently in gpio mode
);
    import pordm_pkg::*;

    localparam int RSRC = $bits(pordm_rst_src_t);

    // ------------------------------------------------------------------
    // synchronisers for everything arriving from outside this clock
    // ------------------------------------------------------------------
    logic [RSRC-1:0] rsrc_meta_r;
    logic [RSRC-1:0] rsrc_sync_r;
    logic            pord_meta_r;
    logic            pord_sync_r;
    logic [PINS-1:0] pin_meta_r;
    logic [PINS-1:0] pin_sync_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rsrc_meta_r <= '0;
            rsrc_sync_r <= '0;
            pord_meta_r <= 1'b0;
            pord_sync_r <= 1'b0;
            pin_meta_r  <= '0;
            pin_sync_r  <= '0;
        end else begin
            rsrc_meta_r <= other_reset;
            rsrc_sync_r <= rsrc_meta_r;
            pord_meta_r <= por_detect_raw;
            pord_sync_r <= pord_meta_r;
            pin_meta_r  <= p0_pin_in;
            pin_sync_r  <= pin_meta_r;
        end
    end

    // any of the other sources returns the circuit to active
    wire other_reset_seen = |rsrc_sync_r;

    // ------------------------------------------------------------------
    // wishbone classic slave: ack one cycle after the request appears
    // ------------------------------------------------------------------
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;

    wire req_live   = wb_req.cyc & wb_req.stb;
    wire req_new    = req_live & ~ack_r;
    // registers change on the edge at which the master samples ack
    wire req_commit = req_live & ack_r & wb_req.we;

    wire hit_por = (wb_req.adr == `PORDM_POR_CTL_OFS);
    wire hit_p0  = (wb_req.adr == `PORDM_P0_CFG_OFS);

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // power-on reset disable key
    // ------------------------------------------------------------------
    logic [15:0] key_r;
    logic [15:0] key_nxt;

    wire [31:0] por_word   = {16'h0000, key_r};
    wire [31:0] por_merged = lane_merge(por_word, wb_req.dat, wb_req.sel);
    // locked writes are acked but change nothing
    wire por_wr_ok = req_commit & hit_por & write_unlocked;

    always_comb begin
        key_nxt = key_r;
        if (por_wr_ok) begin
            key_nxt = por_merged[`PORDM_KEY_MSB:`PORDM_KEY_LSB];
        end
        // another reset source wins over a write in the same cycle
        if (other_reset_seen) begin
            key_nxt = `PORDM_KEY_RST;
        end
    end

    wire key_match_nxt = (key_nxt == `PORDM_POR_KEY);

    // ------------------------------------------------------------------
    // port 0 function and input-type register
    // ------------------------------------------------------------------
    logic [PINS-1:0] schmitt_r;
    logic [PINS-1:0] schmitt_nxt;
    logic [3:0]      alt_r;
    logic [3:0]      alt_nxt;
    logic [PINS-1:0] sel_r;
    logic [PINS-1:0] sel_nxt;

    // reserved bits 12..15 and 24..31 read zero and ignore writes
    wire [31:0] p0_word = {8'h00, schmitt_r, 4'h0, alt_r, sel_r};
    wire [31:0] p0_merged = lane_merge(p0_word, wb_req.dat, wb_req.sel);
    wire p0_wr = req_commit & hit_p0;

    always_comb begin
        schmitt_nxt = schmitt_r;
        alt_nxt     = alt_r;
        sel_nxt     = sel_r;
        if (p0_wr) begin
            schmitt_nxt = p0_merged[`PORDM_SCHMITT_MSB:`PORDM_SCHMITT_LSB];
            alt_nxt     = p0_merged[`PORDM_ALT_MSB:`PORDM_ALT_LSB];
            sel_nxt     = p0_merged[`PORDM_SEL_MSB:`PORDM_SEL_LSB];
        end
    end

    // ------------------------------------------------------------------
    // read mux and answer
    // ------------------------------------------------------------------
    // unmapped addresses read zero, writes to them are dropped
    assign rdat_nxt = hit_por ? por_word :
                      hit_p0  ? p0_word  : 32'h0000_0000;
    assign ack_nxt  = req_new;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= ack_nxt;
            rdat_r <= req_new ? rdat_nxt : rdat_r;
        end
    end

    assign wb_rsp.ack = ack_r;
    assign wb_rsp.dat = rdat_r;

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic por_disabled_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            key_r          <= `PORDM_KEY_RST;
            por_disabled_r <= 1'b0;
            schmitt_r      <= '0;
            alt_r          <= 4'h0;
            sel_r          <= '0;
        end else begin
            key_r          <= key_nxt;
            por_disabled_r <= key_match_nxt;
            schmitt_r      <= schmitt_nxt;
            alt_r          <= alt_nxt;
            sel_r          <= sel_nxt;
        end
    end

    assign por_disabled         = por_disabled_r;
    assign port0_schmitt_enable = schmitt_r;

    // the detector is only gated, never filtered, so a real power event
    // still resets the chip as soon as the key is cleared
    logic por_chip_reset_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            por_chip_reset_r <= 1'b0;
        end else begin
            por_chip_reset_r <= pord_sync_r & ~key_match_nxt;
        end
    end

    assign por_chip_reset = por_chip_reset_r;

    // ------------------------------------------------------------------
    // per-pin function decode
    // ------------------------------------------------------------------
    pordm_func_t func [PINS];

    for (genvar p = 0; p < PINS; p++) begin : g_pin
        pordm_pin_decode #(
            .PIN (p)
        ) u_dec (
            .alt  ((p < 4) ? alt_r[p % 4] : 1'b0),
            .sel  (sel_r[p]),
            .func (func[p])
        );
    end

    // ------------------------------------------------------------------
    // pad and peripheral routing
    // ------------------------------------------------------------------
    logic [PINS-1:0] pin_out_nxt;
    logic [PINS-1:0] pin_oe_nxt;
    logic [PINS-1:0] gpio_nxt;
    logic            brake_nxt;
    logic            adc_nxt;
    logic [2:0]      cap_nxt;

    always_comb begin
        pin_out_nxt = '0;
        pin_oe_nxt  = '0;
        gpio_nxt    = '0;
        brake_nxt   = 1'b0;
        adc_nxt     = 1'b0;
        cap_nxt     = 3'h0;
        for (int p = 0; p < PINS; p++) begin
            unique case (func[p])
                PORDM_FN_GPIO: begin
                    gpio_nxt[p]    = 1'b1;
                    pin_out_nxt[p] = gpio_out[p];
                    pin_oe_nxt[p]  = gpio_oe[p];
                end
                PORDM_FN_PWM: begin
                    if (p < 6) begin
                        pin_out_nxt[p] = pwm_unit0_channel[p % 6];
                        pin_oe_nxt[p]  = 1'b1;
                    end
                end
                PORDM_FN_BRAKE: begin
                    brake_nxt = pin_sync_r[p];
                end
                PORDM_FN_ADC: begin
                    // pins 3 and 7 may both feed the trigger; either pin's synchronised level counts
                    adc_nxt = adc_nxt | pin_sync_r[p];
                end
                PORDM_FN_CAP: begin
                    if (p < 3) begin
                        cap_nxt[p % 3] = pin_sync_r[p];
                    end
                end
                default: begin
                    gpio_nxt[p] = 1'b1;
                end
            endcase
        end
    end

    logic [PINS-1:0] pin_out_r;
    logic [PINS-1:0] pin_oe_r;
    logic [PINS-1:0] gpio_mode_r;
    logic [PINS-1:0] gpio_in_r;
    logic            brake_r;
    logic            adc_r;
    logic [2:0]      cap_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_out_r   <= '0;
            pin_oe_r    <= '0;
            gpio_mode_r <= '1;
            gpio_in_r   <= '0;
            brake_r     <= 1'b0;
            adc_r       <= 1'b0;
            cap_r       <= 3'h0;
        end else begin
            pin_out_r   <= pin_out_nxt;
            pin_oe_r    <= pin_oe_nxt;
            gpio_mode_r <= gpio_nxt;
            gpio_in_r   <= pin_sync_r;
            brake_r     <= brake_nxt;
            adc_r       <= adc_nxt;
            cap_r       <= cap_nxt;
        end
    end

    assign p0_pin_out              = pin_out_r;
    assign p0_pin_oe               = pin_oe_r;
    assign pin_is_gpio             = gpio_mode_r;
    assign gpio_in                 = gpio_in_r;
    assign pwm_unit0_brake_input1  = brake_r;
    assign adc_start_trigger_input = adc_r;
    assign capture_unit1_input     = cap_r;

endmodule // pordm_top

//--- hw/pordm_regs.svh
// register offsets, field positions and reset values of the por-disable and port 0 mux bank
`ifndef PORDM_REGS_SVH
`define PORDM_REGS_SVH

`define PORDM_ADR_W          8
`define PORDM_POR_CTL_OFS    8'h24
`define PORDM_P0_CFG_OFS     8'h30

`define PORDM_POR_KEY        16'h5aa5
`define PORDM_KEY_RST        16'h0000
`define PORDM_KEY_LSB        0
`define PORDM_KEY_MSB        15

`define PORDM_P0_RST         32'h0000_0000
`define PORDM_SEL_LSB        0
`define PORDM_SEL_MSB        7
`define PORDM_ALT_LSB        8
`define PORDM_ALT_MSB        11
`define PORDM_SCHMITT_LSB    16
`define PORDM_SCHMITT_MSB    23

`endif

//--- hw/pordm_pkg.sv
// types shared by the por-disable and port 0 mux bank
package pordm_pkg;

    // one-hot pin function codes
    typedef enum logic [4:0] {
        PORDM_FN_GPIO  = 5'h01,
        PORDM_FN_PWM   = 5'h02,
        PORDM_FN_BRAKE = 5'h04,
        PORDM_FN_ADC   = 5'h08,
        PORDM_FN_CAP   = 5'h10
    } pordm_func_t;

    // wishbone classic request as driven by the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } pordm_wb_req_t;

    // wishbone classic answer
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } pordm_wb_rsp_t;

    // reset sources that bring the power-on reset circuit back
    typedef struct packed {
        logic ext_pin;
        logic watchdog;
        logic window_watchdog;
        logic low_voltage;
        logic brownout;
        logic debugger_cmd;
        logic software_chip;
    } pordm_rst_src_t;

endpackage

//--- hw/pordm_pin_decode.sv
// decodes one port 0 pin's alternate and select bits into its function
`timescale 1ns/1ps
module pordm_pin_decode
    import pordm_pkg::*;
#(
    parameter int PIN = 0
) (
    input  wire logic        alt,   // alternate-select bit, pins 0..3 only
    input  wire logic        sel,   // select bit
    output pordm_pkg::pordm_func_t func // decoded function
);
    import pordm_pkg::*;

    function automatic pordm_func_t decode(input int pin, input logic a, input logic s);
        pordm_func_t f;
        f = PORDM_FN_GPIO;
        if (pin >= 4) begin
            if (s) begin
                unique case (pin)
                    7:       f = PORDM_FN_ADC;
                    6:       f = PORDM_FN_BRAKE;
                    default: f = PORDM_FN_PWM;
                endcase
            end
        end else begin
            // (1,0) is not a defined pair, left as gpio
            unique case ({a, s})
                2'b01:   f = PORDM_FN_PWM;
                2'b11:   f = (pin == 3) ? PORDM_FN_ADC : PORDM_FN_CAP;
                default: f = PORDM_FN_GPIO;
            endcase
        end
        return f;
    endfunction

    assign func = decode(PIN, alt, sel);

endmodule // pordm_pin_decode

//--- tb/pordm_top_asserts.sv
// concurrent checks of the por-disable key and port 0 mux bank at its ports
`timescale 1ns/1ps
`include "pordm_regs.svh"
module pordm_top_asserts
    import pordm_pkg::*;
#(
    parameter int PINS = 8 // port 0 width
) (
    input wire logic                      ref_clk,              // system clock
    input wire logic                      rst_n,                // synchronous reset, active low
    input wire pordm_pkg::pordm_wb_req_t  wb_req,               // bus request
    input wire pordm_pkg::pordm_wb_rsp_t  wb_rsp,               // bus answer
    input wire logic                      write_unlocked,       // protection unlocked
    input wire pordm_pkg::pordm_rst_src_t other_reset,          // other reset sources
    input wire logic                      por_chip_reset,       // power-on reset request
    input wire logic                      por_disabled,         // power-on reset held off
    input wire logic [PINS-1:0]           port0_schmitt_enable, // schmitt enables
    input wire logic [PINS-1:0]           pin_is_gpio           // gpio mode per pin
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    wire logic        req     = wb_req.cyc & wb_req.stb;
    wire logic        wr_done = wb_rsp.ack & req & wb_req.we;
    wire logic        rd_done = wb_rsp.ack & req & !wb_req.we;
    wire logic        ctl_hit = wb_req.adr == `PORDM_POR_CTL_OFS;
    wire logic        p0_hit  = wb_req.adr == `PORDM_P0_CFG_OFS;
    // key writes only count when no other reset source is pending, which would win
    wire logic        key_wr  = wr_done & ctl_hit & (wb_req.sel[1:0] == 2'h3) & write_unlocked & (other_reset == '0);
    wire logic        p0_full_wr = wr_done & p0_hit & (wb_req.sel == 4'hf);
    wire logic [31:0] rsv_mask = ctl_hit ? 32'hffff_0000 : (p0_hit ? 32'hff00_f000 : 32'hffff_ffff);
    logic [31:0]      p0_wdat_r;

    always_ff @(posedge ref_clk) begin
        if (p0_full_wr) begin
            p0_wdat_r <= wb_req.dat;
        end
    end

    a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property ($rose(req) |=> wb_rsp.ack)
        else $error("request not answered in the next cycle");
    a_key_set: assert property (key_wr && wb_req.dat[15:0] == `PORDM_POR_KEY |=> por_disabled)
        else $error("key write did not disable power-on reset");
    a_key_other: assert property (key_wr && wb_req.dat[15:0] != `PORDM_POR_KEY |=> !por_disabled)
        else $error("non-key write left power-on reset disabled");
    a_por_held: assert property (por_disabled |-> !por_chip_reset)
        else $error("chip reset raised while disabled");
    a_other_reset: assert property ((other_reset != '0) |-> ##[1:4] !por_disabled)
        else $error("other reset source did not re-enable power-on reset");
    a_key_locked: assert property (wr_done && ctl_hit && !write_unlocked && !por_disabled |=> !por_disabled)
        else $error("locked key write took effect");
    a_reserved_zero: assert property (rd_done |-> (wb_rsp.dat & rsv_mask) == 32'h0)
        else $error("reserved or unmapped bits read non-zero");
    a_schmitt_follow: assert property (p0_full_wr |-> ##2 port0_schmitt_enable == p0_wdat_r[16 +: PINS])
        else $error("schmitt enables do not follow register");
    a_gpio_follow: assert property (p0_full_wr |-> ##2 pin_is_gpio == ~p0_wdat_r[PINS-1:0])
        else $error("gpio mode does not follow select bits");
endmodule // pordm_top_asserts

//--- tb/pordm_top_tb.sv
// self-checking bench for the por-disable key and port 0 mux bank
`timescale 1ns/1ps
`include "pordm_regs.svh"
module pordm_top_tb;
    import pordm_pkg::*;
    logic           ref_clk;
    logic           rst_n;
    pordm_wb_req_t  wb_req;
    pordm_wb_rsp_t  wb_rsp;
    logic           write_unlocked;
    pordm_rst_src_t other_reset;
    logic           por_detect_raw;
    logic           por_chip_reset;
    logic           por_disabled;
    logic [7:0]     port0_schmitt_enable;
    logic [7:0]     p0_pin_in;
    logic [7:0]     p0_pin_out;
    logic [7:0]     p0_pin_oe;
    logic [7:0]     gpio_out;
    logic [7:0]     gpio_oe;
    logic [7:0]     gpio_in;
    logic [5:0]     pwm_unit0_channel;
    logic           pwm_unit0_brake_input1;
    logic           adc_start_trigger_input;
    logic [2:0]     capture_unit1_input;
    logic [7:0]     pin_is_gpio;
    logic [31:0]    rd;
    int             n_errors;
    int             total_checks;

    pordm_top #(.PINS(8)) pordm_top_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .write_unlocked(write_unlocked),
        .other_reset(other_reset), .por_detect_raw(por_detect_raw), .por_chip_reset(por_chip_reset),
        .por_disabled(por_disabled), .port0_schmitt_enable(port0_schmitt_enable), .p0_pin_in(p0_pin_in),
        .p0_pin_out(p0_pin_out), .p0_pin_oe(p0_pin_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_in(gpio_in), .pwm_unit0_channel(pwm_unit0_channel), .pwm_unit0_brake_input1(pwm_unit0_brake_input1),
        .adc_start_trigger_input(adc_start_trigger_input), .capture_unit1_input(capture_unit1_input),
        .pin_is_gpio(pin_is_gpio));

    always #2 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // read data and ack are taken before the edge's own updates land
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        wb_xfer(1'b1, a, d, s);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb_xfer(1'b0, a, 32'h0, 4'hf);
        check(rd, exp);
    endtask

    // one pin set to (alt, sel), all others gpio; works out every routed output
    task automatic pin_chk(input int m, input logic alt, input logic sel, input logic pad);
        logic [7:0] e_gpio;
        logic [7:0] e_oe;
        logic [7:0] e_out;
        logic       e_brk;
        logic       e_adc;
        logic [2:0] e_cap;
        e_gpio = 8'hff;
        e_oe = gpio_oe;
        e_out = gpio_out;
        e_brk = 1'b0;
        e_adc = 1'b0;
        e_cap = 3'h0;
        if (sel) begin
            e_gpio[m] = 1'b0;
            if ((m < 4 && !alt) || m == 4 || m == 5) begin
                e_oe[m] = 1'b1;
                e_out[m] = pwm_unit0_channel[m];
            end else begin
                e_oe[m] = 1'b0;
                if (m == 6) e_brk = pad;
                else if (m == 7 || m == 3) e_adc = pad;
                else e_cap[m] = pad;
            end
        end
        check({pin_is_gpio, p0_pin_oe, p0_pin_out & p0_pin_oe, 3'h0, pwm_unit0_brake_input1,
               adc_start_trigger_input, capture_unit1_input},
              {e_gpio, e_oe, e_out & e_oe, 3'h0, e_brk, e_adc, e_cap});
        check({24'h0, gpio_in}, {24'h0, {8{pad}}});
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        complete_run();
    end

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        wb_req = '0;
        write_unlocked = 1'b0;
        other_reset = '0;
        por_detect_raw = 1'b0;
        p0_pin_in = 8'h00;
        gpio_out = 8'h5a;
        gpio_oe = 8'hc3;
        pwm_unit0_channel = 6'h15;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check({16'h0, pin_is_gpio, port0_schmitt_enable}, 32'hff00);
        rdchk(`PORDM_POR_CTL_OFS, 32'h0);
        rdchk(`PORDM_P0_CFG_OFS, 32'h0);
        wr(8'h28, 32'hffff_ffff, 4'hf);
        rdchk(8'h28, 32'h0);
        por_detect_raw <= 1'b1;
        wr(`PORDM_POR_CTL_OFS, 32'h0000_5aa5, 4'hf);
        rdchk(`PORDM_POR_CTL_OFS, 32'h0);
        check({30'h0, por_disabled, por_chip_reset}, 32'h1);
        write_unlocked <= 1'b1;
        wr(`PORDM_POR_CTL_OFS, 32'hffff_5aa5, 4'hf);
        check({30'h0, por_disabled, por_chip_reset}, 32'h2);
        rdchk(`PORDM_POR_CTL_OFS, 32'h0000_5aa5);
        wr(`PORDM_POR_CTL_OFS, 32'h0000_5aa4, 4'hf);
        check({30'h0, por_disabled, por_chip_reset}, 32'h1);
        for (int i = 0; i < 7; i++) begin
            wr(`PORDM_POR_CTL_OFS, 32'h0000_5aa5, 4'h3);
            check({31'h0, por_disabled}, 32'h1);
            other_reset <= pordm_rst_src_t'(7'h01 << i);
            @(posedge ref_clk);
            other_reset <= '0;
            repeat (6) @(posedge ref_clk);
            check({31'h0, por_disabled}, 32'h0);
            rdchk(`PORDM_POR_CTL_OFS, 32'h0);
        end
        wr(`PORDM_P0_CFG_OFS, 32'hffff_ffff, 4'hf);
        rdchk(`PORDM_P0_CFG_OFS, 32'h00ff_0fff);
        check({24'h0, port0_schmitt_enable}, 32'hff);
        wr(`PORDM_P0_CFG_OFS, 32'h00a5_0000, 4'h4);
        rdchk(`PORDM_P0_CFG_OFS, 32'h00a5_0fff);
        check({24'h0, port0_schmitt_enable}, 32'ha5);
        for (int m = 0; m < 8; m++) begin
            for (int k = 1; k < 4; k++) begin
                if (m > 3 && k > 1) continue;
                wr(`PORDM_P0_CFG_OFS, (32'(k[1]) << (8 + m)) | (32'(k[0]) << m), 4'hf);
                for (int v = 0; v < 2; v++) begin
                    p0_pin_in <= (v == 1) ? 8'hff : 8'h00;
                    repeat (5) @(posedge ref_clk);
                    pin_chk(m, k[1], k[0], v == 1);
                end
            end
        end
        complete_run();
    end
endmodule // pordm_top_tb

bind pordm_top pordm_top_asserts #(.PINS(PINS)) pordm_top_asserts_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .write_unlocked(write_unlocked),
    .other_reset(other_reset), .por_chip_reset(por_chip_reset), .por_disabled(por_disabled),
    .port0_schmitt_enable(port0_schmitt_enable), .pin_is_gpio(pin_is_gpio));
